// >>> rtl/dqos_top.sv
// Functional notes
// - short on output A sets channel's A error flag, shown in error byte bit 4
// - A error flag holds until error acknowledge clears it
// - B error flag set by short on B or direct request for both high
// - B error flag holds until error acknowledge clears it
// - level byte bit 1 shows present level of output A, 1 is high
// - level byte bit 2 shows present level of output B, 1 is high
// - direct mode with both manual bits set: A high, B low, B error set
// - source select 1: outputs follow pulse processing, manual bits ignored
// - source select 0: output A follows manual level A
// - source select 0 and manual A low: output B follows manual level B
`timescale 1ns/1ns
module dqos_top
  import dqos_pkg::*;
#(
  parameter int unsigned CH = dqos_pkg::NUM_CH
) (
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [dqos_pkg::WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [dqos_pkg::WB_SEL_W-1:0] wb_sel_i,
  input  wire logic [dqos_pkg::WB_DAT_W-1:0] wb_dat_i,
  output logic      [dqos_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic [dqos_pkg::NUM_CH-1:0]   pulse_a_in,
  input  wire logic [dqos_pkg::NUM_CH-1:0]   pulse_b_in,
  input  wire logic [dqos_pkg::NUM_CH-1:0]   short_a_in,
  input  wire logic [dqos_pkg::NUM_CH-1:0]   short_b_in,
  output logic      [dqos_pkg::NUM_CH-1:0]   output_a,
  output logic      [dqos_pkg::NUM_CH-1:0]   output_b,
  output logic                               irq
);

  import dqos_pkg::*;

  if (CH != NUM_CH) begin : g_bad_ch
    $error("dqos_top: register map serves exactly two channels");
  end

  // ==========================================================
  // bus decode
  logic             wr_stb;
  logic [5:0]       idx;
  logic [REG_W-1:0] wdat;

  assign idx    = wb_adr_i[7:2];
  assign wdat   = wb_dat_i[REG_W-1:0];
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

  // ==========================================================
  // per-channel state
  logic [REG_W-1:0] ctrl_ff   [NUM_CH];
  logic [NUM_CH-1:0] sa_meta_ff;
  logic [NUM_CH-1:0] sa_sync_ff;
  logic [NUM_CH-1:0] sb_meta_ff;
  logic [NUM_CH-1:0] sb_sync_ff;
  logic [NUM_CH-1:0] err_a_ff;
  logic [NUM_CH-1:0] err_b_ff;
  logic [NUM_CH-1:0] both_req;
  logic [NUM_CH-1:0] set_a;
  logic [NUM_CH-1:0] set_b;
  logic [NUM_CH-1:0] nxt_out_a;
  logic [NUM_CH-1:0] nxt_out_b;
  logic [REG_W-1:0]  err_byte  [NUM_CH];
  logic [REG_W-1:0]  lvl_byte  [NUM_CH];

  // short-circuit pins come from outside the clock domain
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sa_meta_ff <= '0;
      sa_sync_ff <= '0;
      sb_meta_ff <= '0;
      sb_sync_ff <= '0;
    end else begin
      sa_meta_ff <= short_a_in;
      sa_sync_ff <= sa_meta_ff;
      sb_meta_ff <= short_b_in;
      sb_sync_ff <= sb_meta_ff;
    end
  end

  genvar g;
  for (g = 0; g < NUM_CH; g++) begin : g_ch
    localparam logic [5:0] CTRL_IDX = (g == 0) ? IDX_CH0_CTRL : IDX_CH1_CTRL;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        ctrl_ff[g] <= CTRL_RST;
      end else if (wr_stb && idx == CTRL_IDX) begin
        ctrl_ff[g] <= wdat & CTL_WR_MASK;
      end
    end

    // output source selection
    always_comb begin
      both_req[g] = 1'b0;
      if (ctrl_ff[g][CTL_SRC_BIT]) begin
        nxt_out_a[g] = pulse_a_in[g];
        nxt_out_b[g] = pulse_b_in[g];
      end else begin
        nxt_out_a[g] = ctrl_ff[g][CTL_MA_BIT];
        nxt_out_b[g] = ctrl_ff[g][CTL_MB_BIT] && !ctrl_ff[g][CTL_MA_BIT];
        both_req[g]  = ctrl_ff[g][CTL_MA_BIT] && ctrl_ff[g][CTL_MB_BIT];
      end
    end

    assign set_a[g] = sa_sync_ff[g];
    assign set_b[g] = sb_sync_ff[g] || both_req[g];

    // sticky error flags, a new event beats the acknowledge
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        err_a_ff[g] <= 1'b0;
      end else if (set_a[g]) begin
        err_a_ff[g] <= 1'b1;
      end else if (ctrl_ff[g][CTL_ACK_BIT]) begin
        err_a_ff[g] <= 1'b0;
      end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        err_b_ff[g] <= 1'b0;
      end else if (set_b[g]) begin
        err_b_ff[g] <= 1'b1;
      end else if (ctrl_ff[g][CTL_ACK_BIT]) begin
        err_b_ff[g] <= 1'b0;
      end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        output_a[g] <= 1'b0;
        output_b[g] <= 1'b0;
      end else begin
        output_a[g] <= nxt_out_a[g];
        output_b[g] <= nxt_out_b[g];
      end
    end

    always_comb begin
      err_byte[g]            = '0;
      err_byte[g][ERR_A_BIT] = err_a_ff[g];
      err_byte[g][ERR_B_BIT] = err_b_ff[g];
      lvl_byte[g]            = '0;
      lvl_byte[g][LVL_A_BIT] = output_a[g];
      lvl_byte[g][LVL_B_BIT] = output_b[g];
    end
  end

  // ==========================================================
  // interrupt status, write one to clear, set wins
  logic [IRQ_W-1:0] irq_sts_ff;
  logic [IRQ_W-1:0] irq_msk_ff;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_set = {set_b[1], set_a[1], set_b[0], set_a[0]};
  assign irq_clr = (wr_stb && idx == IDX_IRQ_STS) ? wdat[IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_sts_ff <= '0;
    end else begin
      irq_sts_ff <= (irq_sts_ff & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_msk_ff <= IRQ_MSK_RST;
    end else if (wr_stb && idx == IDX_IRQ_MSK) begin
      irq_msk_ff <= wdat[IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_sts_ff & irq_msk_ff);
    end
  end

  // ==========================================================
  // wishbone answer, one wait state, unmapped reads zero
  logic [REG_W-1:0] nxt_rdat;

  always_comb begin
    unique case (idx)
      IDX_CH0_ERR:  nxt_rdat = err_byte[0];
      IDX_CH0_LVL:  nxt_rdat = lvl_byte[0];
      IDX_CH1_ERR:  nxt_rdat = err_byte[1];
      IDX_CH1_LVL:  nxt_rdat = lvl_byte[1];
      IDX_CH0_CTRL: nxt_rdat = ctrl_ff[0];
      IDX_CH1_CTRL: nxt_rdat = ctrl_ff[1];
      IDX_IRQ_STS:  nxt_rdat = {{(REG_W-IRQ_W){1'b0}}, irq_sts_ff};
      IDX_IRQ_MSK:  nxt_rdat = {{(REG_W-IRQ_W){1'b0}}, irq_msk_ff};
      default:      nxt_rdat = '0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= {{(WB_DAT_W-REG_W){1'b0}}, nxt_rdat};
    end
  end

endmodule

// >>> rtl/dqos_pkg.sv
// ============================================================
// shared constants
package dqos_pkg;

  localparam int unsigned WB_ADR_W  = 8;
  localparam int unsigned WB_DAT_W  = 32;
  localparam int unsigned WB_SEL_W  = 4;
  localparam int unsigned REG_W     = 8;
  localparam int unsigned NUM_CH    = 2;
  localparam int unsigned IRQ_W     = 4;

  // ==========================================================
  // register indices, byte address is index times four
  localparam logic [5:0] IDX_CH0_ERR  = 6'h00;
  localparam logic [5:0] IDX_CH0_LVL  = 6'h02;
  localparam logic [5:0] IDX_CH1_ERR  = 6'h08;
  localparam logic [5:0] IDX_CH1_LVL  = 6'h0a;
  localparam logic [5:0] IDX_CH0_CTRL = 6'h10;
  localparam logic [5:0] IDX_CH1_CTRL = 6'h11;
  localparam logic [5:0] IDX_IRQ_STS  = 6'h12;
  localparam logic [5:0] IDX_IRQ_MSK  = 6'h13;

  // ==========================================================
  // field positions
  localparam int unsigned ERR_A_BIT   = 4;
  localparam int unsigned ERR_B_BIT   = 5;
  localparam int unsigned LVL_A_BIT   = 1;
  localparam int unsigned LVL_B_BIT   = 2;
  localparam int unsigned CTL_SRC_BIT = 1;
  localparam int unsigned CTL_ACK_BIT = 2;
  localparam int unsigned CTL_MA_BIT  = 3;
  localparam int unsigned CTL_MB_BIT  = 4;
  localparam logic [REG_W-1:0] CTL_WR_MASK = 8'h1e;

  // ==========================================================
  // reset values
  localparam logic [REG_W-1:0] CTRL_RST    = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MSK_RST = 4'h0;

endpackage

// >>> sim/dqos_load.sv
`timescale 1ns/1ns
module dqos_load (
  input  wire logic       clk,
  input  wire logic [3:0] sh,
  output logic      [1:0] pa,
  output logic      [1:0] pb,
  output logic      [1:0] sa,
  output logic      [1:0] sb
);
  // new sequencer levels every cycle
  always @(posedge clk) {pa, pb} <= 4'($urandom);
  assign sa = sh[1:0];
  assign sb = sh[3:2];
endmodule

// >>> sim/dqos_chk_sva.sv
`timescale 1ns/1ns
module dqos_chk (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  pulse_a_in,
  input wire logic [1:0]  pulse_b_in,
  input wire logic [1:0]  output_a,
  input wire logic [1:0]  output_b,
  input wire logic        irq
);
  // ====
  // ch0 control copy: src, ack, man a, man b
  logic [3:0] ctl_ff;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_ff <= 4'h0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i[7:2] == 6'h10) begin
      ctl_ff <= wb_dat_i[4:1];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("ack uncalled");
  a_idle_noack: assert property (!wb_stb_i |=> !wb_ack_o) else $error("ack when idle");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
  a_out_a: assert property (output_a[0] == $past(ctl_ff[0] ? pulse_a_in[0] : ctl_ff[2]))
    else $error("output a wrong");
  a_out_b: assert property (output_b[0] == $past(ctl_ff[0] ? pulse_b_in[0] : ctl_ff[3] & !ctl_ff[2]))
    else $error("output b wrong");
  a_lvl_read: assert property ($rose(wb_ack_o) && !wb_we_i && wb_adr_i[7:2] == 6'h02 |->
    wb_dat_o[2:1] == {$past(output_b[0]), $past(output_a[0])}) else $error("level byte wrong");
  a_irq_cause: assert property ($fell(irq) |-> $past(wb_we_i, 2)) else $error("irq dropped alone");
  c_irq: cover property (irq);
  c_both: cover property (ctl_ff == 4'hc);
  c_pulse: cover property (ctl_ff[0] && output_a[0]);
endmodule

// >>> sim/dq_output_select_feedback_bench.sv
`timescale 1ns/1ns
module dq_output_select_feedback_bench;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
  logic [7:0]  adr = 8'h0;
  logic [31:0] dat = 32'h0, rdat, d;
  logic [3:0]  sh = 4'h0;
  logic [1:0]  pa, pb, sa, sb, oa, ob;
  logic [31:0] exp_q[$];
  int          n_fail = 0;
  int          check_count = 0;

  dqos_load ld_u (.clk(sys_clk), .sh(sh), .pa(pa), .pb(pb), .sa(sa), .sb(sb));
  dqos_top dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pulse_a_in(pa), .pulse_b_in(pb), .short_a_in(sa), .short_b_in(sb),
    .output_a(oa), .output_b(ob), .irq(irq));

  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic [31:0] v, input logic w);
    @(posedge sys_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, v};
    do @(posedge sys_clk); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(a, 32'h0, 1'b0);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ====
  // read data checker
  always @(posedge sys_clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      ck(rdat, exp_q.pop_front());
    end
  end

  initial forever #5 sys_clk = ~sys_clk;

  initial begin
    #100us;
    n_fail++;
    complete_run;
  end

  initial begin
    void'($urandom(4));
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h7c, 32'h0);
    wb(8'h00, 32'hff, 1'b1);
    rd(8'h00, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wb(8'h40, {27'h0, i[1], i[0], 3'h0}, 1'b1);
      rd(8'h08, {29'h0, i[1] & !i[0], i[0], 1'b0});
    end
    rd(8'h00, 32'h20);
    rd(8'h48, 32'h2);
    wb(8'h4c, 32'h2, 1'b1);
    @(posedge sys_clk);
    ck({31'h0, irq}, 32'h1);
    wb(8'h40, 32'h4, 1'b1);
    wb(8'h40, 32'h0, 1'b1);
    rd(8'h00, 32'h0);
    wb(8'h48, 32'h2, 1'b1);
    @(posedge sys_clk);
    ck({31'h0, irq}, 32'h0);
    wb(8'h40, 32'h1a, 1'b1);
    rd(8'h00, 32'h0);
    sh <= 4'h4;
    repeat (8) @(posedge sys_clk);
    sh <= 4'h0;
    rd(8'h00, 32'h20);
    repeat (3) begin
      d = $urandom & 32'h18;
      wb(8'h44, d, 1'b1);
      rd(8'h28, {29'h0, d[4] & !d[3], d[3], 1'b0});
    end
    wb(8'h44, 32'h4, 1'b1);
    wb(8'h44, 32'h0, 1'b1);
    sh <= 4'h2;
    repeat (8) @(posedge sys_clk);
    sh <= 4'h0;
    rd(8'h20, 32'h10);
    rd(8'h20, 32'h10);
    wb(8'h44, 32'h4, 1'b1);
    rd(8'h20, 32'h0);
    complete_run;
  end
endmodule

bind dqos_top dqos_chk chk_u (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pulse_a_in, .pulse_b_in, .output_a, .output_b, .irq);
